// [rtl/sbdo_pkg.sv]
`default_nettype none
package sbdo_pkg;
    // ****************************************
    // Status byte layout
    // ****************************************
    localparam int BIT_CALC = 0;
    localparam int BIT_STORE = 1;
    localparam int BIT_SYNTAX = 2;
    localparam int BIT_OVER = 3;
    localparam int BIT_SUPPLY = 4;
    localparam int BIT_ERROR = 5;
    localparam int BIT_SRQ = 6;
    localparam int BIT_FIXED = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [1:0] SERIAL_TOP = 2'h1;
    // ****************************************
    // Buffer and record geometry
    // ****************************************
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int TEXT_CHARS = 16;
    localparam int TEXT_BITS = 128;
    localparam int SETUP_SLOTS = 6;
    localparam logic [2:0] OPT_SLOT = 3'h5;
    localparam logic [2:0] SLOT_DONE = 3'h6;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] LINES_ONE = 3'h3;
    localparam logic [2:0] LINES_TWO = 3'h5;
    localparam int MODEL_BITS = 48;
    localparam int VERSION_BITS = 32;
    localparam int MODEL_LEN = 17;
    localparam int STR3_LEN = 3;
    localparam int FIELD_LEN = 7;
    localparam int FIELD_BITS = 56;
    localparam int DIGITS = 4;
    localparam logic [4:0] IDX_ZERO = 5'h00;
    localparam logic [4:0] IDX_ONE = 5'h01;
    localparam logic [4:0] IDX_STATE = 5'h03;
    localparam logic [4:0] IDX_DIGIT = 5'h04;
    localparam logic [4:0] LEN_HDR = 5'h04;
    localparam logic [4:0] LEN_DAT = 5'h08;
    localparam logic [4:0] LEN_NUM = 5'h08;
    localparam logic [4:0] LEN_MODEL = 5'h11;
    localparam logic [4:0] LEN_TEXT = 5'h10;
    localparam logic [4:0] LEN_END = 5'h03;
    localparam logic [4:0] LEN_ONE = 5'h01;
    // ****************************************
    // Characters and codes
    // ****************************************
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [23:0] STR_END = "END";
    localparam logic [23:0] STR_NO = "NO.";
    localparam logic [23:0] STR_MDL = "MDL";
    localparam logic [31:0] STR_REV = ";REV";
    localparam logic [55:0] NODATA_FIELD = "888888.";
    localparam logic [1:0] ST_NORMAL = 2'h0;
    localparam logic [1:0] ST_OVERFLOW = 2'h1;
    localparam logic [1:0] ST_NODATA = 2'h2;
    localparam logic [2:0] PT_PERCENT = 3'h0;
    localparam logic [2:0] PT_INH2O = 3'h1;
    localparam logic [2:0] PT_INHG = 3'h2;
    localparam logic [2:0] PT_PSI = 3'h3;
    localparam logic [2:0] PT_KPA = 3'h4;
    localparam logic [2:0] PT_KGF = 3'h5;
    localparam logic [2:0] PT_MMH2O = 3'h6;
    localparam logic [2:0] PT_MMHG = 3'h7;
    localparam logic [1:0] DT_VOLT = 2'h0;
    localparam logic [1:0] DT_PVOLT = 2'h1;
    localparam logic [1:0] DT_PAMP = 2'h2;
    localparam logic [1:0] DT_ERR = 2'h3;
    typedef enum {MODE_VALUE, MODE_RECALL, MODE_SETUP} sbdo_mode_e;
    typedef enum {SEG_IDLE, SEG_NUM, SEG_COMMA_A, SEG_PHDR, SEG_PDAT, SEG_COMMA_B,
        SEG_DHDR, SEG_DDAT, SEG_MODEL, SEG_TEXT, SEG_ENDW, SEG_CR, SEG_LF} sbdo_seg_e;
endpackage
`default_nettype wire

// [rtl/sbdo_stream_if.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Character stream with handshake
// ****************************************
interface sbdo_stream_if #(parameter int WIDTH = 8) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // sbdo_stream_if
`default_nettype wire

// [rtl/sbdo_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Output character buffer
// ****************************************
module sbdo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    sbdo_stream_if.snk wrSide,
    output logic [WIDTH-1:0] rdData,
    output logic rdValid,
    input wire logic rdReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;

    // Handshake terms; full stalls the formatter
    assign wrSide.ready = count_reg != (AW+1)'(DEPTH);
    assign rdValid = count_reg != '0;
    assign doWr = wrSide.valid & wrSide.ready;
    assign doRd = rdValid & rdReady;
    assign rdData = mem[rdPtr_reg];

    // Storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= wrSide.data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doWr && !doRd) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRd && !doWr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // sbdo_fifo
`default_nettype wire

// [rtl/sbdo_status_byte.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Sticky status byte with event mask
// ****************************************
module sbdo_status_byte
    import sbdo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic computeDoneEvt,
    input wire logic storeDoneEvt,
    input wire logic autoStoreActive,
    input wire logic syntaxErrEvt,
    input wire logic overEvt,
    input wire logic supplyOverloadEvt,
    input wire logic [7:0] errCauseCode,
    input wire logic maskWrite,
    input wire logic [7:0] maskData,
    input wire logic readStrobe,
    output logic [7:0] statusImage,
    output logic srqActive,
    output logic [7:0] errorCode
);
    logic [7:0] mask_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] setBits;
    logic calcOk;
    logic syntaxOk;
    logic overOk;

    // Masked done, syntax and over events never reach the byte
    assign calcOk = computeDoneEvt & mask_reg[BIT_CALC];
    assign syntaxOk = syntaxErrEvt & mask_reg[BIT_SYNTAX];
    assign overOk = overEvt & mask_reg[BIT_OVER];
    assign srqActive = status_reg[BIT_SRQ];

    // New events OR in; a set wins over the read clear
    always_comb begin
        setBits = STATUS_RESET;
        setBits[BIT_CALC] = calcOk;
        setBits[BIT_STORE] = storeDoneEvt & autoStoreActive;
        setBits[BIT_SYNTAX] = syntaxOk;
        setBits[BIT_OVER] = overOk;
        setBits[BIT_SUPPLY] = supplyOverloadEvt;
        setBits[BIT_ERROR] = syntaxOk | overOk;
        setBits[BIT_SRQ] = calcOk | syntaxOk | overOk;
        status_next = (readStrobe ? STATUS_RESET : status_reg) | setBits;
        status_next[BIT_FIXED] = 1'b0;
    end

    // Status, mask, poll image and error cause
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            statusImage <= STATUS_RESET;
            errorCode <= CAUSE_RESET;
        end else begin
            status_reg <= status_next;
            if (maskWrite) begin
                mask_reg <= maskData;
            end
            if (readStrobe) begin
                statusImage <= status_reg;
            end
            if (syntaxErrEvt || overEvt) begin
                errorCode <= errCauseCode;
            end
        end
    end
endmodule // sbdo_status_byte
`default_nettype wire

// [rtl/sbdo_reporter.sv]
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Unmasked done, syntax, over set SRQ bit
// - Syntax or over sets error summary bit
// - Supply overload shutdown sets bit five
// - Overrange or overflow sets bit four, cause kept
// - Command errors set bit three, cause kept
// - Auto store write sets bit two
// - Finished computation sets bit one
// - Bits stick until polled, then clear
// - Masked done, syntax, over leave byte and SRQ untouched
// - Top bit zero; serial byte bit seven one
// - Value is four header, eight data chars
// - Header emission can be switched off
// - Header gives type code and state char
// - Meter state F when meter is off
// - Data is sign then seven digit chars
// - Two channels joined by comma, then terminator
// - Recall records start with number field
// - Setup lines: model first, END last, option
module sbdo_reporter
    import sbdo_pkg::*;
#(
    parameter logic [MODEL_BITS-1:0] MODEL_CODE = "000000", // Arbitrary value
    parameter logic [VERSION_BITS-1:0] SW_VERSION = "1.00" // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic computeDoneEvt,
    input wire logic storeDoneEvt,
    input wire logic autoStoreActive,
    input wire logic syntaxErrEvt,
    input wire logic overEvt,
    input wire logic supplyOverloadEvt,
    input wire logic [7:0] errCauseCode,
    input wire logic maskWrite,
    input wire logic [7:0] maskData,
    input wire logic pollRead,
    input wire logic serialStatusRead,
    output logic [7:0] pollByte,
    output logic [7:0] serialByte,
    output logic srqOut,
    output logic [7:0] errorCode,
    input wire logic valueCmd,
    input wire logic recallCmd,
    input wire logic setupCmd,
    input wire logic headerEnable,
    input wire logic twoChannel,
    input wire logic optionFitted,
    input wire logic [2:0] pressType,
    input wire logic [1:0] pressState,
    input wire logic pressNeg,
    input wire logic [FIELD_BITS-1:0] pressField,
    input wire logic meterOn,
    input wire logic [1:0] meterType,
    input wire logic [1:0] meterState,
    input wire logic meterNeg,
    input wire logic [FIELD_BITS-1:0] meterField,
    input wire logic [15:0] recallNumber,
    input wire logic recallPresent,
    input wire logic [SETUP_SLOTS-1:0][TEXT_BITS-1:0] setupText,
    output logic busy,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady
);
    // ****************************************
    // Declarations
    // ****************************************
    localparam int LINE_BITS = MODEL_LEN * 8;
    localparam logic [MODEL_LEN*8-1:0] MODEL_LINE = {STR_MDL, MODEL_CODE, STR_REV, SW_VERSION};
    sbdo_mode_e mode_reg;
    sbdo_seg_e seg_reg;
    sbdo_seg_e segAfter;
    logic [4:0] idx_reg;
    logic [4:0] segLen;
    logic [2:0] slot_reg;
    logic [2:0] slotAfter;
    logic [2:0] baseLines;
    logic endSent_reg;
    logic hdrOn_reg;
    logic [7:0] curChar;
    logic skipRest;
    logic step;
    logic lastChar;
    logic anyRead;
    logic [7:0] statusImage;
    sbdo_stream_if #(.WIDTH(FIFO_WIDTH)) charIf ();

    // ****************************************
    // Helper functions
    // ****************************************
    // Character i of a string of len characters, first character leftmost
    function automatic logic [7:0] pickChar(input logic [MODEL_LEN*8-1:0] s,
                                            input int len, input logic [4:0] i);
        return s[8*(len-1-int'(i)) +: 8];
    endfunction

    // Pressure header type letters
    function automatic logic [23:0] pressTypeStr(input logic [2:0] t);
        logic [23:0] s;
        s = "KPA";
        unique case (t)
            PT_PERCENT: s = "PP ";
            PT_INH2O: s = "IHO";
            PT_INHG: s = "IHG";
            PT_PSI: s = "PSI";
            PT_KPA: s = "KPA";
            PT_KGF: s = "KGF";
            PT_MMH2O: s = "MHO";
            PT_MMHG: s = "MHG";
        endcase
        return s;
    endfunction

    // Meter header type letters
    function automatic logic [23:0] meterTypeStr(input logic [1:0] t);
        logic [23:0] s;
        s = "V  ";
        unique case (t)
            DT_VOLT: s = "V  ";
            DT_PVOLT: s = "PV ";
            DT_PAMP: s = "PA ";
            DT_ERR: s = "ERR";
        endcase
        return s;
    endfunction

    // State character; code three is unused and reads as no data
    function automatic logic [7:0] stateChar(input logic [1:0] st);
        logic [7:0] c;
        c = CH_E;
        unique case (st)
            ST_NORMAL: c = CH_N;
            ST_OVERFLOW: c = CH_O;
            default: c = CH_E;
        endcase
        return c;
    endfunction

    // One data character: sign first, then digits or the no-data filler
    function automatic logic [7:0] dataChar(input logic neg, input logic noData,
                                            input logic [FIELD_BITS-1:0] f,
                                            input logic [4:0] i);
        logic [7:0] c;
        c = CH_SPACE;
        if (i == IDX_ZERO) begin
            c = (neg && !noData) ? CH_MINUS : CH_SPACE;
        end else if (noData) begin
            c = pickChar(LINE_BITS'(NODATA_FIELD), FIELD_LEN, i - IDX_ONE);
        end else begin
            c = pickChar(LINE_BITS'(f), FIELD_LEN, i - IDX_ONE);
        end
        return c;
    endfunction

    // ****************************************
    // Status byte
    // ****************************************
    assign anyRead = pollRead | serialStatusRead;

    sbdo_status_byte u_status (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .computeDoneEvt(computeDoneEvt),
        .storeDoneEvt(storeDoneEvt),
        .autoStoreActive(autoStoreActive),
        .syntaxErrEvt(syntaxErrEvt),
        .overEvt(overEvt),
        .supplyOverloadEvt(supplyOverloadEvt),
        .errCauseCode(errCauseCode),
        .maskWrite(maskWrite),
        .maskData(maskData),
        .readStrobe(anyRead),
        .statusImage(statusImage),
        .srqActive(srqOut),
        .errorCode(errorCode)
    );

    // Parallel and serial images of the same flops
    assign pollByte = statusImage;
    assign serialByte = {SERIAL_TOP, statusImage[BIT_ERROR:BIT_CALC]};

    // ****************************************
    // Record sequencer
    // ****************************************
    // Characters in the current segment
    always_comb begin
        segLen = LEN_ONE;
        unique case (seg_reg)
            SEG_NUM: segLen = LEN_NUM;
            SEG_PHDR, SEG_DHDR: segLen = LEN_HDR;
            SEG_PDAT, SEG_DDAT: segLen = LEN_DAT;
            SEG_MODEL: segLen = LEN_MODEL;
            SEG_TEXT: segLen = LEN_TEXT;
            SEG_ENDW: segLen = LEN_END;
            default: segLen = LEN_ONE;
        endcase
    end

    // Next setup slot after a text line
    assign baseLines = twoChannel ? LINES_TWO : LINES_ONE;
    always_comb begin
        slotAfter = slot_reg + 3'h1;
        if (slot_reg == OPT_SLOT) begin
            slotAfter = SLOT_DONE;
        end else if (slotAfter == baseLines) begin
            slotAfter = optionFitted ? OPT_SLOT : SLOT_DONE;
        end
    end

    // Segment order for each record kind
    always_comb begin
        segAfter = SEG_IDLE;
        unique case (seg_reg)
            SEG_IDLE: segAfter = SEG_IDLE;
            SEG_NUM: segAfter = SEG_COMMA_A;
            SEG_COMMA_A: segAfter = hdrOn_reg ? SEG_PHDR : SEG_PDAT;
            SEG_PHDR: segAfter = SEG_PDAT;
            SEG_PDAT: segAfter = twoChannel ? SEG_COMMA_B : SEG_CR;
            SEG_COMMA_B: segAfter = hdrOn_reg ? SEG_DHDR : SEG_DDAT;
            SEG_DHDR: segAfter = SEG_DDAT;
            SEG_DDAT: segAfter = SEG_CR;
            SEG_MODEL, SEG_TEXT, SEG_ENDW: segAfter = SEG_CR;
            SEG_CR: segAfter = SEG_LF;
            SEG_LF: begin
                if (mode_reg != MODE_SETUP || endSent_reg) begin
                    segAfter = SEG_IDLE;
                end else if (slot_reg != SLOT_DONE) begin
                    segAfter = SEG_TEXT;
                end else begin
                    segAfter = SEG_ENDW;
                end
            end
        endcase
    end

    // Character at the current position
    always_comb begin
        curChar = CH_NUL;
        unique case (seg_reg)
            SEG_IDLE: curChar = CH_NUL;
            SEG_NUM: begin
                if (idx_reg < IDX_STATE) begin
                    curChar = pickChar(LINE_BITS'(STR_NO), STR3_LEN, idx_reg);
                end else if (idx_reg == IDX_STATE) begin
                    curChar = recallPresent ? CH_SPACE : CH_E;
                end else begin
                    curChar = CH_ZERO + 8'(recallNumber[4*(DIGITS-1-int'(idx_reg - IDX_DIGIT)) +: 4]);
                end
            end
            SEG_COMMA_A, SEG_COMMA_B: curChar = CH_COMMA;
            SEG_PHDR: begin
                if (idx_reg < IDX_STATE) begin
                    curChar = pickChar(LINE_BITS'(pressTypeStr(pressType)), STR3_LEN, idx_reg);
                end else begin
                    curChar = stateChar(pressState);
                end
            end
            SEG_PDAT: curChar = dataChar(pressNeg, pressState == ST_NODATA, pressField, idx_reg);
            SEG_DHDR: begin
                if (idx_reg < IDX_STATE) begin
                    curChar = pickChar(LINE_BITS'(meterTypeStr(meterType)), STR3_LEN, idx_reg);
                end else begin
                    curChar = meterOn ? stateChar(meterState) : CH_F;
                end
            end
            SEG_DDAT: curChar = dataChar(meterNeg, !meterOn || meterState == ST_NODATA, meterField, idx_reg);
            SEG_MODEL: curChar = pickChar(MODEL_LINE, MODEL_LEN, idx_reg);
            SEG_TEXT: curChar = pickChar(LINE_BITS'(setupText[slot_reg]), TEXT_CHARS, idx_reg);
            SEG_ENDW: curChar = pickChar(LINE_BITS'(STR_END), STR3_LEN, idx_reg);
            SEG_CR: curChar = CH_CR;
            SEG_LF: curChar = CH_LF;
        endcase
    end

    // A NUL in a text line ends that line early
    assign skipRest = (seg_reg == SEG_TEXT) && (curChar == CH_NUL);
    assign charIf.valid = (seg_reg != SEG_IDLE) && !skipRest;
    assign charIf.data = curChar;
    assign step = (charIf.valid && charIf.ready) || skipRest;
    assign lastChar = skipRest || (idx_reg == segLen - LEN_ONE);
    assign busy = seg_reg != SEG_IDLE;

    // Segment and position; new commands wait for the idle state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            seg_reg <= SEG_IDLE;
            idx_reg <= IDX_ZERO;
        end else if (seg_reg == SEG_IDLE) begin
            idx_reg <= IDX_ZERO;
            if (valueCmd) begin
                seg_reg <= headerEnable ? SEG_PHDR : SEG_PDAT;
            end else if (recallCmd) begin
                seg_reg <= SEG_NUM;
            end else if (setupCmd) begin
                seg_reg <= SEG_MODEL;
            end
        end else if (step) begin
            if (lastChar) begin
                seg_reg <= segAfter;
                idx_reg <= IDX_ZERO;
            end else begin
                idx_reg <= idx_reg + IDX_ONE;
            end
        end
    end

    // Record kind and header choice held for the whole record
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= MODE_VALUE;
            hdrOn_reg <= 1'b1;
        end else if (seg_reg == SEG_IDLE) begin
            hdrOn_reg <= headerEnable;
            if (valueCmd) begin
                mode_reg <= MODE_VALUE;
            end else if (recallCmd) begin
                mode_reg <= MODE_RECALL;
            end else if (setupCmd) begin
                mode_reg <= MODE_SETUP;
            end
        end
    end

    // Setup line bookkeeping
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_reg <= SLOT_FIRST;
            endSent_reg <= 1'b0;
        end else if (seg_reg == SEG_IDLE) begin
            slot_reg <= SLOT_FIRST;
            endSent_reg <= 1'b0;
        end else if (step && lastChar) begin
            if (seg_reg == SEG_TEXT) begin
                slot_reg <= slotAfter;
            end
            if (seg_reg == SEG_ENDW) begin
                endSent_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Output buffer
    // ****************************************
    sbdo_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wrSide(charIf),
        .rdData(txData),
        .rdValid(txValid),
        .rdReady(txReady)
    );
endmodule // sbdo_reporter
`default_nettype wire

// [tb/sbdo_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// Status byte and stream checks
// ********
module sbdo_sva (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic computeDoneEvt,
    input wire logic syntaxErrEvt,
    input wire logic overEvt,
    input wire logic pollRead,
    input wire logic srqOut,
    input wire logic valueCmd,
    input wire logic busy,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] errCauseCode,
    input wire logic [7:0] pollByte,
    input wire logic [7:0] serialByte,
    input wire logic [7:0] errorCode,
    input wire logic [7:0] txData
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Any event that may raise the request bit
    wire logic anyEvt = computeDoneEvt | syntaxErrEvt | overEvt;
    fixed_bits_a: assert property (!pollByte[7] && serialByte[7:6] == 2'h1)
        else $error("fixed status bits wrong");
    serial_copy_a: assert property (serialByte[5:0] == pollByte[5:0])
        else $error("serial byte differs from poll byte");
    error_sum_a: assert property (pollByte[5] == (pollByte[3] | pollByte[2]))
        else $error("error summary bit wrong");
    srq_image_a: assert property (pollByte[6] == (|{pollByte[3:2], pollByte[0]}))
        else $error("request bit without cause");
    srq_cause_a: assert property ($rose(srqOut) |-> $past(anyEvt))
        else $error("request raised without event");
    poll_clear_a: assert property (pollRead && !anyEvt |=> !srqOut)
        else $error("request not cleared by poll");
    cause_keep_a: assert property (syntaxErrEvt || overEvt |=> errorCode == $past(errCauseCode))
        else $error("cause code not captured");
    start_busy_a: assert property (valueCmd && !busy |=> busy)
        else $error("record did not start");
    tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("stream data dropped while stalled");
endmodule // sbdo_sva
`default_nettype wire

// [tb/sbdo_sink.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// Controller reading the character stream
// ********
module sbdo_sink (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady
);
    logic [1:0] cnt = 2'h0;
    logic [7:0] got[$];
    // Slow mode accepts one char in four
    assign txReady = !slow || cnt == 2'h0;
    always @(posedge sys_clk) begin
        cnt <= cnt + 2'h1;
        if (txValid && txReady) got.push_back(txData);
    end
endmodule // sbdo_sink
`default_nettype wire

// [tb/sbdo_reporter_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// Reporter bench
// ********
module sbdo_reporter_tb import sbdo_pkg::*;;
    logic sys_clk = 0, arst_n = 0, computeDoneEvt, storeDoneEvt, autoStoreActive, syntaxErrEvt;
    logic overEvt, supplyOverloadEvt, maskWrite, pollRead, serialStatusRead, valueCmd;
    logic recallCmd, setupCmd, headerEnable, twoChannel, optionFitted, pressNeg, meterOn;
    logic meterNeg, recallPresent, slow, srqOut, busy, txValid, txReady;
    logic [7:0] errCauseCode, maskData, pollByte, serialByte, errorCode, txData;
    logic [2:0] pressType;
    logic [1:0] pressState, meterType, meterState;
    logic [55:0] pressField, meterField;
    logic [15:0] recallNumber;
    logic [5:0][127:0] setupText;
    int errorCnt = 0, checksDone = 0;
    string N = "\015\012";
    always #5 sys_clk = ~sys_clk;
    sbdo_reporter DUT (.*);
    sbdo_sink sink (.*);
    task tick; @(posedge sys_clk); #1; endtask
    task check(input logic [31:0] g, input logic [31:0] e);
        checksDone++;
        if (g !== e) begin
            errorCnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, g, e);
        end
    endtask
    task giveVerdict;
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Pulse events: compute, store, syntax, over, supply
    task ev(input logic [4:0] v);
        {computeDoneEvt, storeDoneEvt, syntaxErrEvt, overEvt, supplyOverloadEvt} = v;
        tick;
        {computeDoneEvt, storeDoneEvt, syntaxErrEvt, overEvt, supplyOverloadEvt} = 5'h00;
        tick;
    endtask
    task poll(input logic [7:0] e, input logic ser);
        {serialStatusRead, pollRead} = {ser, !ser};
        tick;
        {serialStatusRead, pollRead} = 2'h0;
        check(ser ? serialByte : pollByte, e);
        tick;
    endtask
    // Start a record, wait for the stream to drain, compare every char
    task automatic rec(input logic [2:0] c, input string e);
        int n = 0;
        sink.got.delete();
        e = {e, N};
        {valueCmd, recallCmd, setupCmd} = c;
        tick;
        {valueCmd, recallCmd, setupCmd} = 3'h0;
        while ((busy || txValid) && n < 2000) begin tick; n++; end
        check(sink.got.size(), e.len());
        foreach (sink.got[i]) check(sink.got[i], e[i]);
        $display("record test done");
    endtask
    initial begin
        {computeDoneEvt, storeDoneEvt, autoStoreActive, syntaxErrEvt, overEvt} = 5'h00;
        {supplyOverloadEvt, maskWrite, pollRead, serialStatusRead, valueCmd} = 5'h00;
        {recallCmd, setupCmd, twoChannel, optionFitted, pressNeg, meterOn} = 6'h00;
        {meterNeg, recallPresent, slow, headerEnable} = 4'h1;
        {errCauseCode, maskData, recallNumber} = 32'h1100_0002;
        {pressType, pressState, meterType, meterState} = {PT_KPA, ST_NORMAL, DT_VOLT, ST_NORMAL};
        {pressField, meterField} = {"130.000", "04.0000"};
        setupText = {6{"L", 120'h0}};
        repeat (12) @(posedge sys_clk);
        #1 arst_n = 1;
        poll(8'h00, 0);
        ev(5'h02);
        check(srqOut, 1);
        poll(8'h68, 0);
        check(errorCode, 8'h11);
        poll(8'h00, 0);
        ev(5'h04);
        ev(5'h10);
        poll(8'h65, 1);
        check(pollByte & 8'h41, 8'h41);
        {maskData, maskWrite} = 9'h001;
        tick;
        maskWrite = 0;
        ev(5'h1E);
        poll(8'h00, 0);
        autoStoreActive = 1;
        ev(5'h09);
        poll(8'h12, 0);
        $display("status test done");
        slow = 1;
        rec(3'h4, "KPAN 130.000");
        {slow, twoChannel, pressState} = {2'h1, ST_OVERFLOW};
        rec(3'h4, "KPAO 130.000,V  F 888888.");
        {meterOn, pressNeg, headerEnable, meterNeg} = 4'hD;
        rec(3'h4, "-130.000,-04.0000");
        {twoChannel, headerEnable, pressState} = {2'h1, ST_NODATA};
        rec(3'h2, "NO.E0002,KPAE 888888.");
        optionFitted = 1;
        rec(3'h1, {"MDL000000;REV1.00", N, "L", N, "L", N, "L", N, "L", N, "END"});
        giveVerdict;
    end
    initial begin
        #100000;
        errorCnt++;
        giveVerdict;
    end
endmodule // sbdo_reporter_tb
bind sbdo_reporter sbdo_sva chk (.*);
`default_nettype wire
